// ==== src/port_edge_irq_and_pin_config.sv ====
/*
 * Edge-interrupt selector for port 0 pins 0..3 and mode selector for port 1
 * pins 4..7, set through two bank-one registers. Assumes pins arrive
 * asynchronously and the core bus is synchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module port_edge_irq_and_pin_config (
   input wire logic mclk, // Core clock, 25 MHz
   input wire logic nrst, // Synchronous reset, active low
   input wire port_cfg_pkg::reg_req_t req, // Register access request
   output logic [7:0] rdata, // Read data, one cycle after rd
   output logic rvalid, // Read data valid pulse
   input wire logic [3:0] port0_pin, // Port 0 pins 3..0, asynchronous
   output logic [3:0] external_irq_line, // Interrupt request pulses, lines 3..0
   output port_cfg_pkg::pin_ctl_t pin_ctl // Port 1 pins 7..4 drive control
);

   logic [7:0] port0_edge_interrupt_config_r;
   logic [7:0] port1_upper_pin_config_r;
   logic [3:0] sync1_r, sync2_r, sync3_r;
   logic [3:0] level_r;
   logic [3:0] irq_r;

   function automatic logic hit(input port_cfg_pkg::reg_req_t r, input logic [7:0] a);
      hit = r.bank_one && (r.addr == a);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port0_edge_interrupt_config_r <= port_cfg_pkg::RESET_PORT0_EDGE_CFG;
      end else if (req.wr && hit(req, port_cfg_pkg::ADDR_PORT0_EDGE_CFG)) begin
         port0_edge_interrupt_config_r <= req.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port1_upper_pin_config_r <= port_cfg_pkg::RESET_PORT1_UPPER_CFG;
      end else if (req.wr && hit(req, port_cfg_pkg::ADDR_PORT1_UPPER_CFG)) begin
         port1_upper_pin_config_r <= req.wdata;
      end
   end

   // Read sees the value before a same-cycle write
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata <= port_cfg_pkg::RDATA_UNMAPPED;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd && hit(req, port_cfg_pkg::ADDR_PORT0_EDGE_CFG)) begin
            rdata <= port0_edge_interrupt_config_r;
         end else if (req.rd && hit(req, port_cfg_pkg::ADDR_PORT1_UPPER_CFG)) begin
            rdata <= port1_upper_pin_config_r;
         end else begin
            rdata <= port_cfg_pkg::RDATA_UNMAPPED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   // Chain runs through reset so the level tracker can start from the pin
   always_ff @(posedge mclk) begin
      sync1_r <= port0_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
   end

   // Level moves only when stages two and three agree, filtering one-cycle glitches
   generate
      for (genvar i = 0; i < port_cfg_pkg::NUM_EDGE_PINS; i++) begin : g_edge
         port_cfg_pkg::edge_mode_t mode;
         logic settled;
         assign mode = port_cfg_pkg::edge_mode_t'(port0_edge_interrupt_config_r[i*2 +: 2]);
         assign settled = (sync2_r[i] == sync3_r[i]) && (sync3_r[i] != level_r[i]);

         always_ff @(posedge mclk) begin
            if (!nrst) begin
               // Pin held high at release is not an edge; needs the full three-cycle reset
               level_r[i] <= sync2_r[i];
               irq_r[i] <= 1'b0;
            end else begin
               if (settled) begin
                  level_r[i] <= sync3_r[i];
               end
               unique case (mode)
                  port_cfg_pkg::EDGE_OFF: irq_r[i] <= 1'b0;
                  port_cfg_pkg::EDGE_FALL: irq_r[i] <= settled && !sync3_r[i];
                  port_cfg_pkg::EDGE_RISE: irq_r[i] <= settled && sync3_r[i];
                  port_cfg_pkg::EDGE_BOTH: irq_r[i] <= settled;
               endcase
            end
         end
      end
   endgenerate

   assign external_irq_line = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // Upper pin mode decode

   generate
      for (genvar j = 0; j < port_cfg_pkg::NUM_UPPER_PINS; j++) begin : g_pin
         port_cfg_pkg::pin_mode_t pm;
         assign pm = port_cfg_pkg::pin_mode_t'(port1_upper_pin_config_r[j*2 +: 2]);
         assign pin_ctl.out_en[j] = (pm == port_cfg_pkg::PIN_PUSH_PULL);
         assign pin_ctl.pull_up[j] = (pm == port_cfg_pkg::PIN_INPUT_PULLUP);
         // Code 10 on pins 4 and 5 leaves the pin a plain input
         assign pin_ctl.alt_fn[j] = (pm == port_cfg_pkg::PIN_ALT) && port_cfg_pkg::ALT_CAPABLE[j];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_pin0_fall;
      @(posedge mclk) disable iff (!nrst)
      ($past(port0_edge_interrupt_config_r[1:0]) == 2'h1 && $fell(level_r[0])) |-> irq_r[0];
   endproperty
   a_pin0_fall: assert property (p_pin0_fall) else $error("pin 0 falling edge missed");

   property p_pin0_off;
      @(posedge mclk) disable iff (!nrst)
      ($past(port0_edge_interrupt_config_r[1:0]) == 2'h0) |-> !irq_r[0];
   endproperty
   a_pin0_off: assert property (p_pin0_off) else $error("pin 0 request while disabled");

   property p_pin3_both;
      @(posedge mclk) disable iff (!nrst)
      ($past(port0_edge_interrupt_config_r[7:6]) == 2'h3) |-> (irq_r[3] == $changed(level_r[3]));
   endproperty
   a_pin3_both: assert property (p_pin3_both) else $error("pin 3 both-edge mismatch");

   property p_pin2_rise_only;
      @(posedge mclk) disable iff (!nrst)
      irq_r[2] && $past(port0_edge_interrupt_config_r[5:4]) == 2'h2 |-> $rose(level_r[2]);
   endproperty
   a_pin2_rise_only: assert property (p_pin2_rise_only) else $error("pin 2 request without rise");

   property p_pin4_none;
      @(posedge mclk) disable iff (!nrst)
      port1_upper_pin_config_r[1:0] == 2'h2 |-> !(pin_ctl.out_en[0] || pin_ctl.pull_up[0] || pin_ctl.alt_fn[0]);
   endproperty
   a_pin4_none: assert property (p_pin4_none) else $error("pin 4 code 10 gave a function");

   property p_edge_cfg_rw;
      @(posedge mclk) disable iff (!nrst)
      (req.wr && req.bank_one && req.addr == port_cfg_pkg::ADDR_PORT0_EDGE_CFG) ##1
      (req.rd && !req.wr && req.bank_one && req.addr == port_cfg_pkg::ADDR_PORT0_EDGE_CFG)
      |=> (rvalid && rdata == $past(req.wdata, 2));
   endproperty
   a_edge_cfg_rw: assert property (p_edge_cfg_rw) else $error("edge config readback wrong");

   property p_reset_input;
      @(posedge mclk) !nrst |=> (port1_upper_pin_config_r == 8'h00 && pin_ctl == '0
                                 && port0_edge_interrupt_config_r == 8'h00);
   endproperty
   a_reset_input: assert property (p_reset_input) else $error("reset values wrong");

   property p_pin7_alt;
      @(posedge mclk) disable iff (!nrst)
      port1_upper_pin_config_r[7:6] == 2'h2 |-> (pin_ctl.alt_fn[3] && !pin_ctl.out_en[3]);
   endproperty
   a_pin7_alt: assert property (p_pin7_alt) else $error("pin 7 analog function missing");

   property p_pin5_none;
      @(posedge mclk) disable iff (!nrst)
      port1_upper_pin_config_r[3:2] == 2'h2 |-> !pin_ctl.alt_fn[1];
   endproperty
   a_pin5_none: assert property (p_pin5_none) else $error("pin 5 code 10 gave analog");

   property p_read_valid;
      @(posedge mclk) disable iff (!nrst)
      req.rd |=> rvalid;
   endproperty
   a_read_valid: assert property (p_read_valid) else $error("read strobe without valid");

   property p_unmapped_read;
      @(posedge mclk) disable iff (!nrst)
      (req.rd && !hit(req, port_cfg_pkg::ADDR_PORT0_EDGE_CFG) && !hit(req, port_cfg_pkg::ADDR_PORT1_UPPER_CFG))
      |=> (rdata == port_cfg_pkg::RDATA_UNMAPPED);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned data");

   property p_bank_zero_ignored;
      @(posedge mclk) disable iff (!nrst)
      (req.wr && !req.bank_one)
      |=> ($stable(port0_edge_interrupt_config_r) && $stable(port1_upper_pin_config_r));
   endproperty
   a_bank_zero_ignored: assert property (p_bank_zero_ignored) else $error("write outside bank one landed");

   property p_pin6_pullup;
      @(posedge mclk) disable iff (!nrst)
      port1_upper_pin_config_r[5:4] == 2'h1 |-> (pin_ctl.pull_up[2] && !pin_ctl.out_en[2] && !pin_ctl.alt_fn[2]);
   endproperty
   a_pin6_pullup: assert property (p_pin6_pullup) else $error("pin 6 pull-up mode wrong");

   property p_pin1_needs_edge;
      @(posedge mclk) disable iff (!nrst)
      irq_r[1] |-> $changed(level_r[1]);
   endproperty
   a_pin1_needs_edge: assert property (p_pin1_needs_edge) else $error("pin 1 request without a transition");

   c_irq0: cover property (@(posedge mclk) disable iff (!nrst) irq_r[0]);
   c_irq3_twice: cover property (@(posedge mclk) disable iff (!nrst) irq_r[3] ##[1:20] irq_r[3]);
   c_pin_push: cover property (@(posedge mclk) disable iff (!nrst) pin_ctl.out_en[2]);
   c_read_upper: cover property (@(posedge mclk) disable iff (!nrst) rvalid && rdata != 8'h00);
   c_alt_pin6: cover property (@(posedge mclk) disable iff (!nrst) pin_ctl.alt_fn[2]);

endmodule : port_edge_irq_and_pin_config

`default_nettype wire

// ==== src/port_cfg_pkg.sv ====
/*
 * Constants and carrier types for the port edge-interrupt and upper pin
 * configuration block. Assumes an 8-bit register-addressed core bus with a
 * bank select line.
 */
package port_cfg_pkg;

   localparam int unsigned NUM_EDGE_PINS = 4;
   localparam int unsigned NUM_UPPER_PINS = 4;
   localparam int unsigned FIELD_W = 2;
   localparam int unsigned SYNC_STAGES = 3;

   localparam logic [7:0] ADDR_PORT0_EDGE_CFG = 8'hE3;
   localparam logic [7:0] ADDR_PORT1_UPPER_CFG = 8'hE4;
   localparam logic [7:0] RESET_PORT0_EDGE_CFG = 8'h00;
   localparam logic [7:0] RESET_PORT1_UPPER_CFG = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Upper pins whose code 10 selects the analog alternative function
   localparam logic [3:0] ALT_CAPABLE = 4'hC;

   typedef enum logic [1:0] {
      EDGE_OFF = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_RISE = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_mode_t;

   typedef enum logic [1:0] {
      PIN_INPUT = 2'h0,
      PIN_INPUT_PULLUP = 2'h1,
      PIN_ALT = 2'h2,
      PIN_PUSH_PULL = 2'h3
   } pin_mode_t;

   typedef struct packed {
      logic bank_one;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] out_en;
      logic [3:0] pull_up;
      logic [3:0] alt_fn;
   } pin_ctl_t;

endpackage : port_cfg_pkg

// ==== verif/port_edge_irq_and_pin_config_bench.sv ====
/*
 * Self-checking bench for the port edge-interrupt and upper pin configuration
 * block. Assumes the block answers reads one cycle after the read strobe and
 * pulses its interrupt lines a few cycles after a pin edge.
 */
`timescale 1ns/10ps
`default_nettype none

module port_edge_irq_and_pin_config_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   port_cfg_pkg::reg_req_t req = '0;
   logic [3:0] port0_pin = 4'h0;
   logic [7:0] rdata;
   logic rvalid;
   logic [3:0] external_irq_line;
   port_cfg_pkg::pin_ctl_t pin_ctl;
   int failures = 0;
   int checks_done = 0;

   always #20 mclk = ~mclk;

   port_edge_irq_and_pin_config DUT (
      .mclk(mclk),
      .nrst(nrst),
      .req(req),
      .rdata(rdata),
      .rvalid(rvalid),
      .port0_pin(port0_pin),
      .external_irq_line(external_irq_line),
      .pin_ctl(pin_ctl)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data, input logic bank);
      @(posedge mclk);
      req <= '{bank_one: bank, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : reg_wr

   // Read strobe lasts one cycle; answer is looked at in the cycle it stands
   task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge mclk);
      req <= '{bank_one: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk({7'h00, rvalid, rdata}, {8'h01, exp});
   endtask : reg_rd

   // Write, then read the same register in the very next cycle
   task automatic reg_wr_rd(input logic [7:0] addr, input logic [7:0] data);
      @(posedge mclk);
      req <= '{bank_one: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge mclk);
      req <= '{bank_one: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk({7'h00, rvalid, rdata}, {8'h01, data});
   endtask : reg_wr_rd

   // Counts pulse cycles on all lines, so stray or doubled pulses show up
   task automatic pin_to(input int idx, input logic lvl, input logic hit);
      logic [3:0] seen;
      int cnt;
      seen = 4'h0;
      cnt = 0;
      @(posedge mclk);
      port0_pin[idx] <= lvl;
      repeat (10) begin
         @(posedge mclk);
         #1;
         seen |= external_irq_line;
         if (external_irq_line !== 4'h0) cnt++;
      end
      chk({cnt[7:0], 4'h0, seen}, {7'h00, hit, 4'h0, hit ? (4'h1 << idx) : 4'h0});
   endtask : pin_to

   task automatic conclude;
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      reg_rd(8'hE3, 8'h00);
      reg_rd(8'hE4, 8'h00);
      chk({4'h0, pin_ctl}, 16'h0000);
      reg_wr(8'hE3, 8'hA5, 1'b0);
      reg_rd(8'hE3, 8'h00);
      reg_wr(8'hE3, 8'h5A, 1'b1);
      reg_rd(8'hE3, 8'h5A);
      reg_wr(8'hE4, 8'hC3, 1'b1);
      reg_rd(8'hE4, 8'hC3);
      reg_rd(8'hE5, 8'h00);
      reg_wr_rd(8'hE3, 8'h96);
      reg_wr_rd(8'hE4, 8'h69);
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 4; m++) begin
            reg_wr(8'hE3, 8'(m << (2 * i)), 1'b1);
            pin_to(i, 1'b1, m[1]);
            pin_to(i, 1'b0, m[0]);
         end
      end
      // Code 10 only means something on the two top pins
      for (int j = 0; j < 4; j++) begin
         for (int c = 0; c < 4; c++) begin
            reg_wr(8'hE4, 8'(c << (2 * j)), 1'b1);
            #1;
            chk({4'h0, pin_ctl}, {4'h0, (c == 3) ? (4'h1 << j) : 4'h0, (c == 1) ? (4'h1 << j) : 4'h0,
               (c == 2 && j >= 2) ? (4'h1 << j) : 4'h0});
         end
      end
      // Pins high through reset must not look like edges once enabled
      @(posedge mclk);
      nrst <= 1'b0;
      port0_pin <= 4'hF;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      reg_wr(8'hE3, 8'hFF, 1'b1);
      pin_to(0, 1'b1, 1'b0);
      reg_rd(8'hE3, 8'hFF);
      reg_rd(8'hE4, 8'h00);
      chk({4'h0, pin_ctl}, 16'h0000);
      conclude();
   end

   // Run needs well under 2000 cycles; this allows ten times that
   initial begin
      #800000;
      failures++;
      conclude();
   end
endmodule : port_edge_irq_and_pin_config_bench

`default_nettype wire
